// ---- rtl/vsr_register_port.sv ----
// Serial register port and user register map of the vibration sensor
//
// Function
// R1 - Read uses request frame then data frame
// R2 - Master sends flag low and 7-bit address
// R3 - Low data byte of read request ignored
// R4 - Next frame shifts out full 16-bit register
// R5 - New request accepted while returning data
// R6 - Command register 0x3E, write-only, no reset value
// R7 - Recording control 0x1C read/write, reset 0x1130
// R8 - Error flags 0x3C read-only, reset 0x0000
// R9 - Axis buffers 0x14/0x16/0x18 read-only, reset 0x8000
// R10 - Buffer/record index 0x10/0x12, reset zero
// R11 - Aux pin function 0x36 read/write, reset 0x000F
// R12 - Spectrum average count 0x0E, reset 0x0008
// R13 - Supply/temperature 0x0A/0x0C read-only, reset 0x8000
// R14 - Part identifier at 0x56, request 0x5600
// R15 - Band status 0x40/0x42/0x44 read-only, reset zero
// R16 - Band limits 0x20/0x22 read/write, reset zero
// R17 - Time stamp words 0x4C/0x4E read-only, zero
// R18 - Clock idles high, sample second edge, MSB first
// R19 - Sample input on rise, change output on fall
// R20 - Output driven only while chip select low
// R21 - Flag MSB, then address, then data byte
// R22 - Reserved or write-only reads return zero harmlessly
`timescale 1ns/100ps
`default_nettype none

module vsr_register_port #(
    parameter logic [15:0] PART_ID = 16'h0a5c  // Arbitrary value
) (
    // System clock and reset
    input  wire logic                                         clock,
    input  wire logic                                         nrst,
    // Serial link
    input  wire logic                                         sclk,
    input  wire logic                                         cs_n,
    input  wire logic                                         serial_in,
    output logic                                              serial_out,
    output logic                                              serial_out_oe_n,
    // Read-only values from the device core
    input  wire logic [vsr_pkg::N_RO-1:0][vsr_pkg::WORD_W-1:0] status_word,
    input  wire logic [vsr_pkg::N_RO-1:0]                     status_load,
    // Control values and commands to the device core
    output logic      [vsr_pkg::N_RW-1:0][vsr_pkg::WORD_W-1:0] control_word,
    output vsr_pkg::vsr_command_s                             command,
    output logic                                              wake
);

    // Link side, rising edge: bits of the current frame
    typedef struct packed {
        logic [vsr_pkg::CNT_W-1:0]    count;
        logic [vsr_pkg::WORD_W-2:0]   shift;
    } vsr_rx_frame_s;

    // Link side, rising edge: last complete word and its request toggle
    typedef struct packed {
        logic [vsr_pkg::WORD_W-1:0]   word;
        logic                         req;
    } vsr_rx_hold_s;

    // Link side, falling edge: outgoing word
    typedef struct packed {
        logic                         started;
        logic [vsr_pkg::WORD_W-1:0]   shift;
    } vsr_tx_s;

    // System side
    typedef struct packed {
        logic                                          req_meta;
        logic                                          req_sync;
        logic                                          req_seen;
        logic                                          cs_meta;
        logic                                          cs_sync;
        logic                                          cs_seen;
        logic                                          wake;
        logic [vsr_pkg::WORD_W-1:0]                    hold;
        logic [vsr_pkg::N_RW-1:0][vsr_pkg::WORD_W-1:0] rw;
        logic [vsr_pkg::N_RO-1:0][vsr_pkg::WORD_W-1:0] ro;
        vsr_pkg::vsr_command_s                         command;
    } vsr_core_s;

    vsr_rx_frame_s rxf;
    vsr_rx_frame_s next_rxf;
    vsr_rx_hold_s  rxh;
    vsr_rx_hold_s  next_rxh;
    vsr_tx_s       txs;
    vsr_tx_s       next_txs;
    vsr_core_s     core;
    vsr_core_s     next_core;
    logic          frame_rst_n;

    // Position of an address in the control list, -1 when absent
    function automatic int find_rw(input logic [vsr_pkg::ADDR_W-1:0] a);
        find_rw = -1;
        for (int i = 0; i < vsr_pkg::N_RW; i++) begin
            if (vsr_pkg::RW_ADDR[i] == a) begin
                find_rw = i;
            end
        end
    endfunction

    // Position of an address in the read-only list, -1 when absent
    function automatic int find_ro(input logic [vsr_pkg::ADDR_W-1:0] a);
        find_ro = -1;
        for (int i = 0; i < vsr_pkg::N_RO; i++) begin
            if (vsr_pkg::RO_ADDR[i] == a) begin
                find_ro = i;
            end
        end
    endfunction

    // Register contents seen by a read of a word address
    function automatic logic [vsr_pkg::WORD_W-1:0] read_word(
        input logic [vsr_pkg::ADDR_W-1:0] a,
        input vsr_core_s                  s
    );
        int rw_i;
        int ro_i;
        rw_i = find_rw(a);
        ro_i = find_ro(a);
        read_word = '0;
        if (a == vsr_pkg::ADDR_PART_IDENTIFIER) begin
            read_word = PART_ID; // R14
        end else if (rw_i >= 0) begin
            read_word = s.rw[rw_i];
        end else if (ro_i >= 0) begin
            read_word = s.ro[ro_i];
        end
    endfunction

    // Frame logic is cleared between frames by chip select itself, so it
    // never depends on link clock edges outside a frame
    assign frame_rst_n = nrst & ~cs_n;

    // Receive: one bit per rising edge, MSB first
    always_comb begin
        next_rxf = rxf;
        next_rxh = rxh;
        next_rxf.shift = {rxf.shift[vsr_pkg::WORD_W-3:0], serial_in}; // R19 R18
        next_rxf.count = vsr_pkg::CNT_W'(rxf.count + 1'b1);
        if (rxf.count == vsr_pkg::LAST_BIT) begin
            next_rxh.word = {rxf.shift, serial_in}; // R1
            next_rxh.req  = ~rxh.req;
        end
    end

    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            rxf <= '0;
        end else begin
            rxf <= next_rxf;
        end
    end

    // Held word outlives the frame; the toggle hands it to the system side
    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            rxh <= '0;
        end else begin
            rxh <= next_rxh;
        end
    end

    // Transmit: the first falling edge of a frame loads the answer word,
    // which the system side settled after the previous frame
    always_comb begin
        next_txs = txs;
        if (!txs.started) begin
            next_txs.started = 1'b1;
            next_txs.shift   = core.hold; // R4 R5
        end else begin
            next_txs.shift = {txs.shift[vsr_pkg::WORD_W-2:0], 1'b0}; // R18
        end
    end

    always_ff @(negedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            txs <= '0;
        end else begin
            txs <= next_txs; // R19
        end
    end

    assign serial_out      = txs.shift[vsr_pkg::WORD_W-1];
    assign serial_out_oe_n = cs_n | ~nrst; // R20

    // System side: request handling, register file, command pulses
    always_comb begin
        logic [vsr_pkg::ADDR_W-1:0] addr;
        logic [vsr_pkg::ADDR_W-1:0] word_addr;
        logic [vsr_pkg::BYTE_W-1:0] data;
        logic [vsr_pkg::WORD_W-1:0] cmd_word;
        logic                       upper;
        int                         rw_i;
        addr      = rxh.word[vsr_pkg::FRM_A_HI:vsr_pkg::FRM_A_LO]; // R21 R2
        data      = rxh.word[vsr_pkg::FRM_D_HI:vsr_pkg::FRM_D_LO];
        upper     = addr[0];
        word_addr = {addr[vsr_pkg::ADDR_W-1:1], 1'b0};
        cmd_word  = upper ? {data, 8'h00} : {8'h00, data};
        rw_i      = find_rw(word_addr);

        next_core          = core;
        next_core.req_meta = rxh.req;
        next_core.req_sync = core.req_meta;
        next_core.req_seen = core.req_sync;
        next_core.cs_meta  = cs_n;
        next_core.cs_sync  = core.cs_meta;
        next_core.cs_seen  = core.cs_sync;
        next_core.wake     = core.cs_seen & ~core.cs_sync;
        next_core.command  = '0;

        // Result values update only when the device core loads them
        for (int i = 0; i < vsr_pkg::N_RO; i++) begin
            if (status_load[i]) begin
                next_core.ro[i] = status_word[i]; // R8 R9 R13 R15 R17
            end
        end

        if (core.req_sync != core.req_seen) begin
            if (rxh.word[vsr_pkg::FRM_RNW]) begin
                // Byte write to a control register or the command trigger
                if (rw_i >= 0) begin
                    if (upper) begin
                        next_core.rw[rw_i][15:8] = data; // R7 R10 R11 R12 R16
                    end else begin
                        next_core.rw[rw_i][7:0] = data;
                    end
                end else if (word_addr == vsr_pkg::ADDR_COMMAND_TRIGGER) begin
                    next_core.command.valid         = 1'b1; // R6
                    next_core.command.upper         = upper;
                    next_core.command.data          = data;
                    next_core.command.capture_start = cmd_word[vsr_pkg::CMD_CAPTURE_BIT];
                    next_core.command.records_clear = cmd_word[vsr_pkg::CMD_CLEAR_BIT];
                    next_core.command.flash_update  = cmd_word[vsr_pkg::CMD_FLASH_BIT];
                    next_core.command.power_down    = cmd_word[vsr_pkg::CMD_SLEEP_BIT];
                end
            end
            // For a read, the data byte plays no part in choosing the answer
            // Read the updated copy so a write frame answers with its new value
            next_core.hold = read_word(word_addr, next_core); // R3 R5 R22
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            core <= '0;
            for (int i = 0; i < vsr_pkg::N_RW; i++) begin
                core.rw[i] <= vsr_pkg::RW_RESET[i]; // R7 R10 R11 R12 R16
            end
            for (int i = 0; i < vsr_pkg::N_RO; i++) begin
                core.ro[i] <= vsr_pkg::RO_RESET[i]; // R8 R9 R13 R15 R17
            end
            core.cs_meta <= 1'b1;
            core.cs_sync <= 1'b1;
            core.cs_seen <= 1'b1;
        end else begin
            core <= next_core;
        end
    end

    assign control_word = core.rw;
    assign command      = core.command;
    assign wake         = core.wake;

endmodule

`default_nettype wire

// ---- rtl/vsr_pkg.sv ----
// Constants and carrier types for the vibration sensor serial register port
package vsr_pkg;

    // Word and frame geometry
    localparam int WORD_W   = 16;
    localparam int ADDR_W   = 7;
    localparam int BYTE_W   = 8;
    localparam int CNT_W    = 4;
    localparam logic [CNT_W-1:0] LAST_BIT = 4'hf;

    // Frame field positions: flag, address, data byte
    localparam int FRM_RNW  = 15;
    localparam int FRM_A_HI = 14;
    localparam int FRM_A_LO = 8;
    localparam int FRM_D_HI = 7;
    localparam int FRM_D_LO = 0;

    // Fixed addresses
    localparam logic [ADDR_W-1:0] ADDR_COMMAND_TRIGGER = 7'h3e;
    localparam logic [ADDR_W-1:0] ADDR_PART_IDENTIFIER = 7'h56;

    // Command word bit positions
    localparam int CMD_CAPTURE_BIT = 11;
    localparam int CMD_CLEAR_BIT   = 8;
    localparam int CMD_FLASH_BIT   = 6;
    localparam int CMD_SLEEP_BIT   = 1;

    // Read/write control registers
    localparam int N_RW = 19;
    localparam logic [ADDR_W-1:0] RW_ADDR [0:N_RW-1] = '{
        7'h0e, 7'h10, 7'h12,                 // spectrum_average_count, buffer/record_index
        7'h1a, 7'h1c, 7'h1e,                 // stored_record_count, recording_control, period
        7'h20, 7'h22,                        // band_low_limit, band_high_limit
        7'h24, 7'h26, 7'h28,                 // x/y/z warning levels
        7'h2a, 7'h2c, 7'h2e,                 // x/y/z fault levels
        7'h30, 7'h32, 7'h34,                 // band_select, system level, alarm_config
        7'h36, 7'h38                         // aux_pin_function, general_pin_control
    };
    localparam logic [WORD_W-1:0] RW_RESET [0:N_RW-1] = '{
        16'h0008, 16'h0000, 16'h0000,
        16'h0000, 16'h1130, 16'h0000,
        16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0080,
        16'h000f, 16'h0000
    };

    // Read-only result and status registers
    localparam int N_RO = 26;
    localparam logic [ADDR_W-1:0] RO_ADDR [0:N_RO-1] = '{
        7'h00, 7'h02, 7'h04, 7'h06, 7'h08,   // flash count, x/y/z offsets, record flash count
        7'h0a, 7'h0c,                        // supply_result, temperature_result
        7'h14, 7'h16, 7'h18,                 // x/y/z data buffers
        7'h3c,                               // error_flags
        7'h40, 7'h42, 7'h44,                 // x/y/z band status
        7'h46, 7'h48, 7'h4a,                 // x/y/z worst magnitude
        7'h4c, 7'h4e,                        // record_time_low, record_time_high
        7'h52, 7'h54, 7'h58,                 // batch codes, unit_serial
        7'h70, 7'h72, 7'h74, 7'h76           // x/y/z worst frequency, record_settings
    };
    localparam logic [WORD_W-1:0] RO_RESET [0:N_RO-1] = '{
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h8000, 16'h8000,
        16'h8000, 16'h8000, 16'h8000,
        16'h0000,
        16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000
    };

    // Command trigger write, one clock pulse
    typedef struct packed {
        logic                valid;
        logic                upper;
        logic [BYTE_W-1:0]   data;
        logic                capture_start;
        logic                records_clear;
        logic                flash_update;
        logic                power_down;
    } vsr_command_s;

endpackage

// ---- bench/vsr_checker.sv ----
// Pin and core-side assertions for the serial register port
`timescale 1ns/100ps
`default_nettype none
module vsr_checker (
    // Clocks and reset
    input wire logic clock,
    input wire logic nrst,
    input wire logic sclk,
    // Serial pins
    input wire logic cs_n,
    input wire logic serial_out,
    input wire logic serial_out_oe_n,
    // Core side
    input wire logic [vsr_pkg::N_RW-1:0][vsr_pkg::WORD_W-1:0] control_word,
    input wire vsr_pkg::vsr_command_s command,
    input wire logic wake
);
    logic [3:0] idle_cnt;
    logic       armed;
    logic       rise_bit;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) idle_cnt <= 4'h0;
        else if (!cs_n) idle_cnt <= 4'h0;
        else if (idle_cnt != 4'hf) idle_cnt <= idle_cnt + 4'h1;
    end
    // Bit seen at the last rise of the current frame
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) armed <= 1'b0;
        else begin
            armed <= 1'b1;
            rise_bit <= serial_out;
        end
    end
    oe_follows_cs_a: assert property (@(posedge clock) disable iff (!nrst)
        serial_out_oe_n == cs_n) else $error("output enable does not follow select");
    out_holds_high_a: assert property (@(negedge sclk) disable iff (!nrst)
        armed && !cs_n |-> serial_out == rise_bit) else $error("output moved on a rise");
    cmd_one_pulse_a: assert property (@(posedge clock) disable iff (!nrst)
        command.valid |=> !command.valid) else $error("command pulse too long");
    wake_one_pulse_a: assert property (@(posedge clock) disable iff (!nrst)
        wake |=> !wake) else $error("wake pulse too long");
    idle_no_write_a: assert property (@(posedge clock) disable iff (!nrst)
        idle_cnt == 4'hf |-> $stable(control_word) && !command.valid)
        else $error("register change while idle");
    rec_ctrl_reset_a: assert property (@(posedge clock) disable iff (!nrst)
        $rose(nrst) |-> control_word[4] == 16'h1130) else $error("recording control reset");
    avg_reset_a: assert property (@(posedge clock) disable iff (!nrst)
        $rose(nrst) |-> control_word[0] == 16'h0008) else $error("average count reset");
    aux_reset_a: assert property (@(posedge clock) disable iff (!nrst)
        $rose(nrst) |-> control_word[17] == 16'h000f) else $error("aux pin reset");
    zero_reset_a: assert property (@(posedge clock) disable iff (!nrst)
        $rose(nrst) |-> control_word[7:6] == '0 && control_word[2:1] == '0)
        else $error("index or limit reset");
endmodule
`default_nettype wire

// ---- bench/vsr_spi_master.sv ----
// Behavioural serial master clocking 16-bit frames
`timescale 1ns/100ps
`default_nettype none
module vsr_spi_master (
    // Serial pins
    output logic     sclk,
    output logic     cs_n,
    output logic     serial_in,
    input wire logic miso
);
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        serial_in = 1'b0;
    end
    // One frame, first bit out is the flag
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        cs_n = 1'b0;
        #20;
        for (int i = 15; i >= 0; i--) begin
            sclk = 1'b0;
            serial_in = tx[i];
            #7.5;
            sclk = 1'b1;
            rx[i] = miso;
            #7.5;
        end
        #10 cs_n = 1'b1;
        serial_in = ~serial_in;
        #200;
    endtask
endmodule
`default_nettype wire

// ---- bench/vsr_register_port_bench.sv ----
// Self-checking bench for the serial register port
`timescale 1ns/100ps
`default_nettype none
module vsr_register_port_bench;
    localparam logic [15:0] PID = 16'h1b2d;  // Arbitrary value
    logic clock, nrst, sclk, cs_n, serial_in, serial_out, serial_out_oe_n, wake, have;
    logic [vsr_pkg::N_RO-1:0][15:0] status_word;
    logic [vsr_pkg::N_RO-1:0]       status_load;
    logic [vsr_pkg::N_RW-1:0][15:0] control_word;
    vsr_pkg::vsr_command_s          command, last_cmd;
    logic [15:0] rw_sh [vsr_pkg::N_RW];
    logic [15:0] ro_sh [vsr_pkg::N_RO];
    logic [15:0] pend;
    logic [15:0] cmds [4] = '{16'hbf08, 16'hbe40, 16'hbf01, 16'hbe02};
    int n_errors, n_tests, n_cmd, c, n_wake;
    wire logic miso = serial_out_oe_n ? 1'bz : serial_out;

    vsr_register_port #(.PART_ID(PID)) dut (.clock(clock), .nrst(nrst), .sclk(sclk),
        .cs_n(cs_n), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n), .status_word(status_word),
        .status_load(status_load), .control_word(control_word), .command(command),
        .wake(wake));
    vsr_spi_master m (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .miso(miso));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) if (command.valid === 1'b1) begin
        last_cmd <= command;
        n_cmd <= n_cmd + 1;
    end
    always @(posedge clock) if (wake === 1'b1) n_wake <= n_wake + 1;

    function automatic logic [15:0] expect_word(input logic [6:0] a);
        logic [6:0] w;
        w = {a[6:1], 1'b0};
        expect_word = (w == vsr_pkg::ADDR_PART_IDENTIFIER) ? PID : 16'h0000;
        for (int i = 0; i < vsr_pkg::N_RW; i++) if (vsr_pkg::RW_ADDR[i] == w) expect_word = rw_sh[i];
        for (int i = 0; i < vsr_pkg::N_RO; i++) if (vsr_pkg::RO_ADDR[i] == w) expect_word = ro_sh[i];
    endfunction
    function automatic logic [15:0] cmd_expect(input logic [15:0] w);
        logic u;
        u = w[8];
        cmd_expect = {3'b001, u, w[7:0], u & w[3], u & w[0], ~u & w[6], ~u & w[1]};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic frame(input logic [15:0] w);
        logic [15:0] rx;
        int w0;
        @(posedge clock) #1;
        w0 = n_wake;
        m.xfer(w, rx);
        chk(16'(n_wake - w0), 16'h0001);
        if (have) chk(rx, pend);
        have = 1'b1;
        if (w[15]) for (int i = 0; i < vsr_pkg::N_RW; i++)
            if (vsr_pkg::RW_ADDR[i] == {w[14:9], 1'b0}) begin
                if (w[8]) rw_sh[i][15:8] = w[7:0];
                else rw_sh[i][7:0] = w[7:0];
            end
        pend = expect_word(w[14:8]);
    endtask
    task automatic load_status();
        @(posedge clock) #1;
        for (int i = 0; i < vsr_pkg::N_RO; i++) begin
            status_word[i] = 16'($urandom);
            status_load[i] = 1'($urandom);
            if (status_load[i]) ro_sh[i] = status_word[i];
        end
        @(posedge clock) #1;
        status_load = '0;
    endtask
    task automatic do_reset();
        nrst = 1'b0;
        have = 1'b0;
        for (int i = 0; i < vsr_pkg::N_RW; i++) rw_sh[i] = vsr_pkg::RW_RESET[i];
        for (int i = 0; i < vsr_pkg::N_RO; i++) ro_sh[i] = vsr_pkg::RO_RESET[i];
        repeat (8) @(posedge clock);
        #1 nrst = 1'b1;
        repeat (2) @(posedge clock);
    endtask
    task automatic read_all();
        for (int i = 0; i < vsr_pkg::N_RW; i++)
            frame({1'b0, vsr_pkg::RW_ADDR[i] | 7'(i % 2), 8'($urandom)});
        for (int i = 0; i < vsr_pkg::N_RO; i++)
            frame({1'b0, vsr_pkg::RO_ADDR[i] | 7'(i % 2), 8'($urandom)});
        frame(16'h5600);
        frame(16'h3e5a);
        frame(16'h3a00);
    endtask
    task automatic end_of_test();
        $display("errors %0d, checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        void'($urandom(93));
        {n_errors, n_tests, n_cmd, n_wake} = '0;
        status_word = '0;
        status_load = '0;
        do_reset();
        read_all();
        repeat (60) frame({1'b1, 7'($urandom_range(8'h77)), 8'($urandom)});
        repeat (40) begin
            load_status();
            frame({1'b0, 7'($urandom_range(8'h77)), 8'($urandom)});
        end
        for (int i = 0; i < vsr_pkg::N_RW; i++) chk(control_word[i], rw_sh[i]);
        foreach (cmds[k]) begin
            c = n_cmd;
            frame(cmds[k]);
            chk(16'(n_cmd - c), 16'h0001);
            chk({2'b00, last_cmd}, cmd_expect(cmds[k]));
        end
        read_all();
        do_reset();
        read_all();
        frame(16'h0000);
        end_of_test();
    end
    initial begin
        #1000000;
        n_errors++;
        end_of_test();
    end
endmodule
bind vsr_register_port vsr_checker check_i (.clock(clock), .nrst(nrst), .sclk(sclk),
    .cs_n(cs_n), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .control_word(control_word), .command(command), .wake(wake));
`default_nettype wire
